// ### hw/quad_phase_core_defines.vh
// constants for the quad phase execution core
`ifndef QUAD_PHASE_CORE_DEFINES_VH
`define QUAD_PHASE_CORE_DEFINES_VH
// bus register byte offsets
`define REG_CTRL_OFS 4'h0
`define REG_STATE_OFS 4'h4
`define REG_PC_OFS 4'h8
`define REG_INSTR_OFS 4'hC
// control fields
`define CTRL_RUN_BIT 0
`define CTRL_VAR_LSB 1
`define CTRL_RESET_VAL 3'h0
// register file variants
`define VAR_SMALL 2'h0
`define VAR_EXTRA_PORT 2'h1
`define VAR_BANKED 2'h2
// special function addresses
`define FA_INDIRECT 5'h00
`define FA_PC 5'h02
`define FA_STATUS 5'h03
`define FA_POINTER 5'h04
// status bit positions
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
// phases per instruction cycle
`define PHASE_COUNT 3'h4
// storage: 32 base locations plus 48 banked
`define FILE_DEPTH 80
`define BANK_BASE 7'h20
`define BANK_SIZE 7'h10
`endif

// ### hw/register_bank.v
// byte storage for the data register file
`default_nettype none
module register_bank (
  input wire clk_in,
  input wire wr_en_in,
  input wire [6:0] wr_idx_in,
  input wire [7:0] wr_data_in,
  input wire [6:0] rd_idx_in,
  output wire [7:0] rd_data_out
);
`include "quad_phase_core_defines.vh"
  reg [7:0] mem [0:`FILE_DEPTH-1];

  assign rd_data_out = (rd_idx_in < `FILE_DEPTH) ? mem[rd_idx_in] : 8'h00;

  always @(posedge clk_in)
  begin
    if (wr_en_in && (wr_idx_in < `FILE_DEPTH))
      mem[wr_idx_in] <= wr_data_in;
  end
endmodule
`default_nettype wire

// ### hw/quad_phase_core_exec.v
// fetch, decode and execute core with register file and bus slave
`default_nettype none
module quad_phase_core_exec (
  input wire clk_in,
  input wire rst_n_in,
  output reg [10:0] prog_addr_out,
  input wire [11:0] prog_data_in,
  output wire [3:0] phase_out,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
`include "quad_phase_core_defines.vh"
  // ***********************************
  // reset release
  // ***********************************
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      {rst_sync_r, rst_meta_r} <= 2'b00;
    else
      {rst_sync_r, rst_meta_r} <= {rst_meta_r, 1'b1};
  end
  wire rst_n = rst_sync_r;

  // ***********************************
  // control and phase generator
  // ***********************************
  reg [2:0] ctrl_r;
  wire run = ctrl_r[`CTRL_RUN_BIT];
  wire [1:0] variant = ctrl_r[`CTRL_VAR_LSB+1:`CTRL_VAR_LSB];
  reg [1:0] phase_r;
  wire ph1 = run && (phase_r == 2'd0);
  wire ph2 = run && (phase_r == 2'd1);
  wire ph4 = run && (phase_r == 2'd3);
  assign phase_out = run ? (4'h1 << phase_r) : 4'h0;

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= 2'd0;
    else if (run)
      phase_r <= phase_r + 2'd1;
  end

  // ***********************************
  // pipeline state
  // ***********************************
  reg [10:0] pc_r;
  reg [11:0] fetch_r;
  reg fetch_valid_r;
  reg [11:0] ir_r;
  reg ir_valid_r;
  reg [7:0] acc_r;
  reg [7:0] status_r;
  reg [7:0] pointer_r;
  reg [7:0] operand_r;

  // ***********************************
  // file addressing
  // ***********************************
  function [6:0] map_index;
    input [4:0] fa;
    input [7:0] ptr;
    input [1:0] var_sel;
    reg [4:0] a;
    reg [1:0] bank;
    begin
      a = (fa == `FA_INDIRECT) ? ptr[4:0] : fa;
      bank = ptr[6:5];
      if ((var_sel == `VAR_BANKED) && a[4] && (bank != 2'd0))
        map_index = `BANK_BASE + ({5'h00, bank} - 7'h01) * `BANK_SIZE + {3'h0, a[3:0]};
      else
        map_index = {2'b00, a};
    end
  endfunction

  wire [4:0] file_addr = ir_r[4:0];
  wire [2:0] bit_sel = ir_r[7:5];
  wire dest_file = ir_r[5];
  wire [4:0] eff_addr = (file_addr == `FA_INDIRECT) ? pointer_r[4:0] : file_addr;
  wire ind_null = (file_addr == `FA_INDIRECT) && (pointer_r[4:0] == `FA_INDIRECT);
  wire [6:0] file_idx = map_index(file_addr, pointer_r, variant);
  wire [7:0] bank_rd;

  // special registers sit outside the byte store; every other address except indirect stays in it
  reg [7:0] file_rd;
  always @*
  begin
    if (ind_null)
      file_rd = 8'h00;
    else if (eff_addr == `FA_PC)
      file_rd = pc_r[7:0];
    else if (eff_addr == `FA_STATUS)
      file_rd = status_r;
    else if (eff_addr == `FA_POINTER)
      file_rd = pointer_r;
    else
      file_rd = bank_rd;
  end

  // ***********************************
  // decode and alu
  // ***********************************
  localparam OP_IDLE = 4'd0;
  localparam OP_ADD = 4'd1;
  localparam OP_ANDF = 4'd2;
  localparam OP_ANDL = 4'd3;
  localparam OP_BCLR = 4'd4;
  localparam OP_INV = 4'd5;
  localparam OP_DEC = 4'd6;
  localparam OP_DECSZ = 4'd7;
  localparam OP_ROL = 4'd8;
  localparam OP_ROR = 4'd9;
  localparam OP_JUMP = 4'd10;

  reg [3:0] op;
  always @*
  begin
    casez ({ir_valid_r, ir_r[11:6]})
      7'b1000111: op = OP_ADD;
      7'b1000101: op = OP_ANDF;
      7'b11110??: op = OP_ANDL;
      7'b10100??: op = OP_BCLR;
      7'b1001001: op = OP_INV;
      7'b1000011: op = OP_DEC;
      7'b1001011: op = OP_DECSZ;
      7'b1001101: op = OP_ROL;
      7'b1001100: op = OP_ROR;
      7'b1101???: op = OP_JUMP;
      default: op = OP_IDLE;
    endcase
  end

  reg [7:0] result;
  reg [7:0] flags_nxt;
  reg to_acc;
  reg to_file;
  reg skip;
  reg [8:0] sum9;
  reg [4:0] sum5;
  always @*
  begin
    result = 8'h00;
    flags_nxt = status_r;
    to_acc = 1'b0;
    to_file = 1'b0;
    sum9 = {1'b0, acc_r} + {1'b0, operand_r};
    sum5 = {1'b0, acc_r[3:0]} + {1'b0, operand_r[3:0]};
    case (op)
      OP_ADD: result = sum9[7:0];
      OP_ANDF: result = acc_r & operand_r;
      OP_ANDL: result = acc_r & ir_r[7:0];
      OP_BCLR: result = operand_r & ~(8'h01 << bit_sel);
      OP_INV: result = ~operand_r;
      OP_DEC: result = operand_r - 8'h01;
      OP_DECSZ: result = operand_r - 8'h01;
      OP_ROL: result = {operand_r[6:0], status_r[`ST_CARRY]};
      OP_ROR: result = {status_r[`ST_CARRY], operand_r[7:1]};
      default: result = 8'h00;
    endcase
    skip = (op == OP_DECSZ) && (result == 8'h00);
    if ((op == OP_ADD) || (op == OP_ANDF) || (op == OP_ANDL) || (op == OP_INV) || (op == OP_DEC))
      flags_nxt[`ST_ZERO] = (result == 8'h00);
    if (op == OP_ADD)
    begin
      flags_nxt[`ST_CARRY] = sum9[8];
      flags_nxt[`ST_HALF] = sum5[4];
    end
    if (op == OP_ROL)
      flags_nxt[`ST_CARRY] = operand_r[7];
    if (op == OP_ROR)
      flags_nxt[`ST_CARRY] = operand_r[0];
    if (op == OP_ANDL)
      to_acc = 1'b1;
    else if ((op == OP_BCLR) || (op == OP_ADD) || (op == OP_ANDF) || (op == OP_INV) ||
             (op == OP_DEC) || (op == OP_DECSZ) || (op == OP_ROL) || (op == OP_ROR))
    begin
      to_acc = !dest_file && (op != OP_BCLR);
      to_file = dest_file || (op == OP_BCLR);
    end
  end

  wire wr_file = ph4 && to_file && !ind_null;
  wire wr_special = (eff_addr == `FA_PC) || (eff_addr == `FA_STATUS) || (eff_addr == `FA_POINTER);
  wire flush = (op == OP_JUMP) || skip;

  register_bank u_bank (
    .clk_in(clk_in),
    .wr_en_in(wr_file && !wr_special),
    .wr_idx_in(file_idx),
    .wr_data_in(result),
    .rd_idx_in(file_idx),
    .rd_data_out(bank_rd)
  );

  // ***********************************
  // fetch and execute sequencing
  // ***********************************
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_r <= 11'h000;
      prog_addr_out <= 11'h000;
      fetch_r <= 12'h000;
      fetch_valid_r <= 1'b0;
      ir_r <= 12'h000;
      ir_valid_r <= 1'b0;
      acc_r <= 8'h00;
      status_r <= 8'h00;
      pointer_r <= 8'h00;
      operand_r <= 8'h00;
    end
    else
    begin
      if (ph1)
      begin
        ir_r <= fetch_r;
        ir_valid_r <= fetch_valid_r;
        prog_addr_out <= pc_r;
        pc_r <= pc_r + 11'h001;
      end
      if (ph2)
        operand_r <= file_rd;
      if (ph4)
      begin
        fetch_r <= prog_data_in;
        fetch_valid_r <= !flush;
        if (op == OP_JUMP)
          pc_r <= {2'b00, ir_r[8:0]};
        else if (wr_file && (eff_addr == `FA_PC))
          pc_r <= {pc_r[10:8], result};
        if (to_acc)
          acc_r <= result;
        if (wr_file && (eff_addr == `FA_POINTER))
          pointer_r <= result;
        if (wr_file && (eff_addr == `FA_STATUS))
          status_r <= {result[7:3], flags_nxt[2:0]};
        else
          status_r <= flags_nxt;
      end
    end
  end

  // ***********************************
  // register bus slave
  // ***********************************
  reg aw_got_r;
  reg w_got_r;
  reg [3:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_r <= `CTRL_RESET_VAL;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == `REG_CTRL_OFS)
        begin
          s_axi_bresp <= 2'b00;
          if (w_strb_r[0])
            ctrl_r <= w_data_r[2:0];
        end
        else if ((aw_addr_r == `REG_STATE_OFS) || (aw_addr_r == `REG_PC_OFS) || (aw_addr_r == `REG_INSTR_OFS))
          s_axi_bresp <= 2'b00;
        else
          s_axi_bresp <= 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      // every mapped offset is word aligned, so any low address bit marks an unmapped read
      s_axi_rresp <= (s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      case (s_axi_araddr)
        `REG_CTRL_OFS: s_axi_rdata <= {29'h00000000, ctrl_r};
        `REG_STATE_OFS: s_axi_rdata <= {8'h00, pointer_r, status_r, acc_r};
        `REG_PC_OFS: s_axi_rdata <= {14'h0000, phase_r, 5'h00, pc_r};
        `REG_INSTR_OFS: s_axi_rdata <= {2'b00, fetch_valid_r, fetch_r, 1'b0, ir_valid_r, ir_r, 3'h0};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ### bench/quad_phase_core_props.sv
// assertions on the ports of the quad phase execution core
`default_nettype none
module quad_phase_core_props (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [10:0] prog_addr_out,
  input wire logic [11:0] prog_data_in,
  input wire logic [3:0] phase_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_phase_onehot: assert property (phase_out != 4'h0 |-> $onehot(phase_out))
    else $error("phase not one-hot");
  a_phase_order: assert property (phase_out[0] |=> phase_out[1] ##1 phase_out[2] ##1 phase_out[3] ##1 phase_out[0])
    else $error("phase sequence broken");
  a_addr_stable: assert property ((phase_out[2] || phase_out[3]) |-> $stable(prog_addr_out))
    else $error("program address moved late in cycle");
  a_addr_step: assert property ((phase_out[3] && prog_data_in[11:9] != 3'h5) ##4 phase_out[3]
    |-> ##4 (phase_out[3] && prog_addr_out == $past(prog_addr_out, 4) + 11'h1))
    else $error("program address did not step by one");
  a_jump_target: assert property ((phase_out[3] && prog_data_in[11:9] == 3'h5) ##4 phase_out[3]
    |-> ##4 (prog_addr_out == {2'h0, $past(prog_data_in[8:0], 8)}))
    else $error("jump target not fetched after two cycles");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
endmodule
bind quad_phase_core_exec quad_phase_core_props i_props (.clk_in, .rst_n_in, .prog_addr_out, .prog_data_in,
  .phase_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### bench/prog_mem.sv
// program memory model feeding the core
`default_nettype none
module prog_mem (
  input wire logic clk_in,
  input wire logic [10:0] prog_addr_in,
  output wire logic [11:0] prog_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] mem [16];
  logic [10:0] addr_r;
  logic [11:0] data_r;
  // stale word shows inverted for a cycle after an address change
  always @(posedge clk_in)
  begin
    addr_r <= prog_addr_in;
    data_r <= prog_data_out;
  end
  assign prog_data_out = (prog_addr_in != addr_r) ? ~data_r : mem[prog_addr_in[3:0]];
endmodule
`default_nettype wire

// ### bench/quad_phase_core_exec_tb.sv
// self-checking bench running small programs on the core
`default_nettype none
`include "quad_phase_core_defines.vh"
module quad_phase_core_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [10:0] prog_addr_out;
  logic [11:0] prog_data_in;
  logic [3:0] phase_out;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [31:0] st;
  logic [1:0] rsp;
  // ****************************************
  // programs, word 0 leftmost, and final {status[2:0], acc}
  // ****************************************
  logic [143:0] progs [12] = '{
    144'hE00_168_248_EA3_E5F_000_000_000_000_000_000_A0B, 144'hE00_168_248_EA3_E5C_000_000_000_000_000_000_A0B,
    144'hE00_168_169_248_EC2_1E8_249_E17_168_E00_1C8_A0B, 144'hE00_168_248_E13_1E8_248_000_000_000_000_000_A0B,
    144'hE00_168_248_E02_1E8_0E8_0C8_000_000_000_000_A0B, 144'hE00_168_248_E02_1E8_2E8_E01_248_2E8_E00_000_A0B,
    144'hE00_168_248_EE6_1E8_368_348_000_000_000_000_A0B, 144'hE00_168_248_EFF_1E8_1E8_308_000_000_000_000_A0B,
    144'hE00_168_248_EC7_1E8_4E8_1C8_408_000_000_000_A0B, 144'hE00_164_244_E08_1E4_E00_160_260_E00_1C8_000_A0B,
    144'hE00_168_248_EF0_A06_E00_E3C_000_000_000_000_A0B, 144'hE00_164_170_244_E20_1E4_E00_170_270_164_1D0_A0B};
  logic [10:0] exp_st [12] = '{11'h003, 11'h400, 11'h002, 11'h0EC, 11'h400, 11'h0FE, 11'h199, 11'h2FF,
    11'h10E, 11'h0FF, 11'h030, 11'h400};
  quad_phase_core_exec i_dut (.clk_in, .rst_n_in, .prog_addr_out, .prog_data_in, .phase_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  prog_mem i_mem (.clk_in, .prog_addr_in(prog_addr_out), .prog_data_out(prog_data_in));
  initial forever #12.5 clk_in = ~clk_in;
  // ****************************************
  // bus tasks and checking
  // ****************************************
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_bready);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_rready);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    for (int p = 0; p < 12; p++)
    begin
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      for (int i = 0; i < 16; i++) i_mem.mem[i] = (i < 12) ? progs[p][143 - 12 * i -: 12] : 12'h000;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      axi_rd(`REG_CTRL_OFS);
      check(rd, 32'h0);
      if (p == 0)
      begin
        axi_rd(4'h2);
        check({30'h0, rsp}, 32'h2);
      end
      axi_wr(`REG_CTRL_OFS, {29'h0, 2'(p % 3), 1'b1});
      axi_rd(`REG_CTRL_OFS);
      check(rd, {29'h0, 2'(p % 3), 1'b1});
      repeat (80) @(posedge clk_in);
      axi_rd(`REG_STATE_OFS);
      st = rd;
      check({21'h0, rd[10:0]}, {21'h0, exp_st[p]});
      axi_wr(`REG_STATE_OFS, 32'hFFFFFFFF);
      check({30'h0, rsp}, 32'h0);
      axi_rd(`REG_STATE_OFS);
      check(rd, st);
    end
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
